//--- logic/dds_pkg.sv
package dds_pkg;

  // ****************************************
  // word format
  // ****************************************
  localparam int WORD_W = 12;
  localparam logic [11:0] CODE_HALF = 12'h800;
  localparam logic [11:0] CODE_ZERO = 12'h000;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DACA = 8'h04;
  localparam logic [7:0] ADDR_DACB = 8'h08;
  localparam logic [7:0] ADDR_PINS = 8'h0C;
  localparam logic [7:0] ADDR_SHIFT = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_FREEZE_BIT = 0;
  localparam int PINS_LDA_BIT = 0;
  localparam int PINS_LDB_BIT = 1;
  localparam int PINS_PRESET_BIT = 2;
  localparam int PINS_MSBSEL_BIT = 3;
  localparam int PINS_SHDN_BIT = 4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // pin order: shutdownN, msbSel, presetN, ldbN, ldaN (idle levels)
  localparam logic [4:0] PIN_IDLE = 5'h17;

  // ****************************************
  // bus encodings
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

endpackage : dds_pkg

//--- logic/dds_pin_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser with agreement filter for asynchronous pins
module dds_pin_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinLevel
);
  import dds_pkg::*;

  logic [W-1:0] s1_q, s1_d;
  logic [W-1:0] s2_q, s2_d;
  logic [W-1:0] s3_q, s3_d;
  logic [W-1:0] lvl_q, lvl_d;

  // s1 is only read by s2; a new level counts once stages two and three agree
  always_comb begin
    s1_d = pinIn;
    s2_d = s1_q;
    s3_d = s2_q;
    for (int i = 0; i < W; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  // sync reset to the idle level of each pin
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      lvl_q <= RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign pinLevel = lvl_q;

endmodule : dds_pin_sync

//--- logic/dds_link_shift.sv
`timescale 1ns/10ps
// input shift register, lives entirely on the serial clock
module dds_link_shift (
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic shutdownN,
  input wire logic serial_in,
  output logic [dds_pkg::WORD_W-1:0] shiftWord
);
  import dds_pkg::*;

  logic [WORD_W-1:0] shift_q, shift_d;

  // msb first: each rising edge with select low and shutdownN high moves one bit in
  always_comb begin
    shift_d = shift_q;
    if (!selectN && shutdownN) begin
      shift_d = {shift_q[WORD_W-2:0], serial_in};
    end
  end

  // no reset here: the serial clock may be stopped during system reset
  always_ff @(posedge serialClk) begin
    shift_q <= shift_d;
  end

  assign shiftWord = shift_q;

  AST_LINK_HOLD: assert property (@(posedge serialClk)
    (selectN || !shutdownN) |=> $stable(shift_q))
    else $error("shift register moved while deselected");

  // case equality: with no reset the unfilled bits stay unknown until a
  // whole word has gone in, and they must still compare as unchanged
  AST_LINK_SHIFT: assert property (@(posedge serialClk)
    (!selectN && shutdownN) |=>
      shift_q === {$past(shift_q[WORD_W-2:0]), $past(serial_in)})
    else $error("shift register did not advance one bit");

  AST_LINK_DIRECT: assert property (@(posedge serialClk)
    (!selectN && shutdownN) ##1 (!selectN && shutdownN) |=>
      shift_q[1:0] == {$past(serial_in, 2), $past(serial_in)})
    else $error("sampled bit did not enter shift register directly");

endmodule : dds_link_shift

//--- logic/dds_top.sv
`timescale 1ns/10ps
// Operation
// - select high ignores serial clock and keeps the shift register.
// - each rising serial edge with select low shifts one bit.
// - serial data sampled only on rising serial clock edge.
// - sampled bit enters the shift register with no extra stage.
// - select is active low and never affects the load strobes.
// - strobe falling edge loads its holding register from the shift register.
// - strobes active low; transparent while low, holding while high.
// - first strobe loads channel A only, second loads channel B only.
// - preset forces both holding registers, shift register untouched.
// - preset with preset-select high loads half-scale 800 hex.
// - preset with preset-select low loads all zeros.
// - shutdown ignores all controls and keeps every register.
module dds_top (
  input wire logic clk_sys,
  input wire logic rstn,
  // serial link pins
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic serial_in,
  input wire logic loadAN,
  input wire logic loadBN,
  input wire logic async_preset_n,
  input wire logic presetHalf,
  input wire logic shutdownN,
  // holding register contents toward the converters
  output logic [dds_pkg::WORD_W-1:0] dacA_q,
  output logic [dds_pkg::WORD_W-1:0] dacB_q,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  import dds_pkg::*;

  // ****************************************
  // serial side
  // ****************************************
  logic [WORD_W-1:0] shiftWord;

  // select goes only to the shifter, never near the strobes
  dds_link_shift uShift (
    .serialClk(serialClk),
    .selectN(selectN),
    .shutdownN(shutdownN),
    .serial_in(serial_in),
    .shiftWord(shiftWord)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pinLevel;
  logic ldaAct;
  logic ldbAct;
  logic presetAct;
  logic msbSel;
  logic shdnAct;

  dds_pin_sync #(
    .W(5),
    .RST(PIN_IDLE)
  ) uPins (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinIn({shutdownN, presetHalf, async_preset_n, loadBN, loadAN}),
    .pinLevel(pinLevel)
  );

  // filtered levels, active high inside the block
  assign ldaAct = !pinLevel[0];
  assign ldbAct = !pinLevel[1];
  assign presetAct = !pinLevel[2];
  assign msbSel = pinLevel[3];
  assign shdnAct = !pinLevel[4];

  // ****************************************
  // shift word crossing
  // ****************************************
  logic [WORD_W-1:0] shMeta_q, shMeta_d;
  logic [WORD_W-1:0] shMid_q, shMid_d;
  logic [WORD_W-1:0] shLate_q, shLate_d;
  logic [WORD_W-1:0] shSafe_q, shSafe_d;

  // quasi-static word: the host keeps the serial clock still while a
  // strobe is low; a copy is only taken once stages two and three agree,
  // so a word caught in the middle of a shift never counts
  always_comb begin
    shMeta_d = shiftWord;
    shMid_d = shMeta_q;
    shLate_d = shMid_q;
    shSafe_d = (shMid_q == shLate_q) ? shLate_q : shSafe_q;
  end

  // three stages; the first is read only by the second
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      shMeta_q <= CODE_ZERO;
      shMid_q <= CODE_ZERO;
      shLate_q <= CODE_ZERO;
      shSafe_q <= CODE_ZERO;
    end else begin
      shMeta_q <= shMeta_d;
      shMid_q <= shMid_d;
      shLate_q <= shLate_d;
      shSafe_q <= shSafe_d;
    end
  end

  // ****************************************
  // holding registers
  // ****************************************
  logic [WORD_W-1:0] holdA_q, holdA_d;
  logic [WORD_W-1:0] holdB_q, holdB_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic freeze;

  assign freeze = shdnAct || ctrl_q[CTRL_FREEZE_BIT];

  // shutdown beats preset, preset beats the strobes
  always_comb begin
    holdA_d = holdA_q;
    holdB_d = holdB_q;
    if (freeze) begin
      holdA_d = holdA_q;
      holdB_d = holdB_q;
    end else if (presetAct) begin
      holdA_d = msbSel ? CODE_HALF : CODE_ZERO;
      holdB_d = msbSel ? CODE_HALF : CODE_ZERO;
    end else begin
      // a falling strobe starts the transparent phase, so its first
      // cycle already takes the current shift word
      if (ldaAct) begin
        holdA_d = shSafe_q;
      end
      if (ldbAct) begin
        holdB_d = shSafe_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      holdA_q <= CODE_ZERO;
      holdB_q <= CODE_ZERO;
    end else begin
      holdA_q <= holdA_d;
      holdB_q <= holdB_d;
    end
  end

  assign dacA_q = holdA_q;
  assign dacB_q = holdB_q;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic wrPend_q, wrPend_d;
  logic [7:0] wrAddr_q, wrAddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic resp_q, resp_d;
  logic take;
  logic [7:0] aIdx;

  // zero wait states: only word transfers are expected, narrower ones
  // are accepted as words rather than refused
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign aIdx = {haddr[7:2], 2'h0};

  // write data phase follows the address phase; read data is prepared in
  // the address phase so that it leaves a flip-flop in the data phase
  always_comb begin
    wrPend_d = take && hwrite;
    wrAddr_d = take ? aIdx : wrAddr_q;
    ctrl_d = ctrl_q;
    if (wrPend_q && wrAddr_q == ADDR_CTRL) begin
      ctrl_d = {31'h0, hwdata[CTRL_FREEZE_BIT]};
    end
    rdata_d = 32'h0000_0000;
    if (take && !hwrite) begin
      unique case (aIdx)
        ADDR_CTRL: rdata_d = ctrl_d;
        ADDR_DACA: rdata_d = {20'h0, holdA_q};
        ADDR_DACB: rdata_d = {20'h0, holdB_q};
        ADDR_PINS: begin
          rdata_d[PINS_LDA_BIT] = ldaAct;
          rdata_d[PINS_LDB_BIT] = ldbAct;
          rdata_d[PINS_PRESET_BIT] = presetAct;
          rdata_d[PINS_MSBSEL_BIT] = msbSel;
          rdata_d[PINS_SHDN_BIT] = shdnAct;
        end
        ADDR_SHIFT: rdata_d = {20'h0, shSafe_q};
        default: rdata_d = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
    ready_d = 1'b1;
    resp_d = HRESP_OKAY;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      ctrl_q <= CTRL_RESET;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b1;
      resp_q <= HRESP_OKAY;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      resp_q <= resp_d;
    end
  end

  assign hreadyout = ready_q;
  assign hrdata = rdata_q;
  assign hresp = resp_q;

  // ****************************************
  // checks
  // ****************************************
  AST_SHDN_KEEPS: assert property (@(posedge clk_sys) disable iff (!rstn)
    shdnAct |=> $stable(holdA_q) && $stable(holdB_q))
    else $error("holding register changed during shutdown");

  AST_PRESET_HALF: assert property (@(posedge clk_sys) disable iff (!rstn)
    (presetAct && msbSel && !freeze) |=>
      holdA_q == CODE_HALF && holdB_q == CODE_HALF)
    else $error("preset did not load half scale");

  AST_PRESET_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (presetAct && !msbSel && !freeze) |=>
      holdA_q == CODE_ZERO && holdB_q == CODE_ZERO)
    else $error("preset did not clear holding registers");

  AST_LOAD_A: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ldaAct && !presetAct && !freeze) |=> holdA_q == $past(shSafe_q))
    else $error("channel A not transparent under its strobe");

  AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!ldaAct && !ldbAct && !presetAct) [*2] |=>
      $stable(holdA_q) && $stable(holdB_q))
    else $error("holding register moved with strobes high");

  AST_ONLY_B: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ldbAct && !ldaAct && !presetAct) |=> $stable(holdA_q))
    else $error("channel B strobe disturbed channel A");

  AST_FALL_LOAD: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($fell(pinLevel[1]) && !presetAct && !freeze) |=>
      holdB_q == $past(shSafe_q))
    else $error("falling strobe did not load channel B");

  AST_BUS_READY: assert property (@(posedge clk_sys) disable iff (!rstn)
    take |=> hreadyout && hresp == HRESP_OKAY)
    else $error("bus answer not ready and okay");

  // the second channel mirrors the first; freeze, crossing and bus side follow
  AST_LOAD_B: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ldbAct && !presetAct && !freeze) |=> holdB_q == $past(shSafe_q))
    else $error("channel B not transparent under its strobe");

  AST_ONLY_A: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ldaAct && !ldbAct && !presetAct) |=> $stable(holdB_q))
    else $error("channel A strobe disturbed channel B");

  AST_FALL_LOAD_A: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($fell(pinLevel[0]) && !presetAct && !freeze) |=>
      holdA_q == $past(shSafe_q))
    else $error("falling strobe did not load channel A");

  AST_FREEZE_KEEPS: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctrl_q[CTRL_FREEZE_BIT] |=> $stable(holdA_q) && $stable(holdB_q))
    else $error("holding register changed while frozen by software");

  AST_CROSS_WAIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    (shMid_q != shLate_q) |=> $stable(shSafe_q))
    else $error("shift word taken before two stages agreed");

  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(take && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data not zero outside a read data phase");

  AST_WRITE_CTRL: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrPend_q && wrAddr_q == ADDR_CTRL) |=> ctrl_q == {31'h0, $past(hwdata[CTRL_FREEZE_BIT])})
    else $error("control write did not land");

endmodule : dds_top

//--- tb/dds_host_model.sv
`timescale 1ns/10ps
// ****************************************
// host side of the serial link
// ****************************************
// serial clock only runs inside send, also with select held high when deselect is set; 6 ns period plus slow, stands low between sends
module dds_host_model (
  output logic serialClk,
  output logic selectN,
  output logic serial_in
);
  initial begin
    serialClk = 1'b0;
    selectN = 1'b1;
    serial_in = 1'b0;
  end

  // one twelve-bit word, msb first, 6 ns clock; slow adds a pause after
  // each falling edge, so a steady low level is seen between bits
  task automatic send(input logic [11:0] w, input logic deselect, input int slow);
    int i;
    selectN = deselect;
    #4;
    for (i = 11; i >= 0; i--) begin
      serial_in = w[i];
      #3 serialClk = 1'b1;
      #3 serialClk = 1'b0;
      #(slow);
    end
    #4 selectN = 1'b1;
    // released data line must not look like a held bit
    serial_in = ~w[0];
  endtask : send
  // callers start a frame only while both load strobes are high
endmodule : dds_host_model

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dds_pkg::*;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic loadAN = 1'b1;
  logic loadBN = 1'b1;
  logic async_preset_n = 1'b1;
  logic presetHalf = 1'b0;
  logic shutdownN = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic serialClk, selectN, serial_in, hreadyout, hresp;
  logic [31:0] hrdata;
  logic [WORD_W-1:0] dacA_q, dacB_q;
  logic [31:0] rd;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  dds_host_model dds_host_model_i (.serialClk(serialClk), .selectN(selectN),
    .serial_in(serial_in));

  dds_top dds_top_i (.clk_sys(clk_sys), .rstn(rstn), .serialClk(serialClk),
    .selectN(selectN), .serial_in(serial_in), .loadAN(loadAN), .loadBN(loadBN),
    .async_preset_n(async_preset_n), .presetHalf(presetHalf), .shutdownN(shutdownN),
    .dacA_q(dacA_q), .dacB_q(dacB_q), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  // ****************************************
  // helpers
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // single whole-word transfer; waits on hready, the timeout ends any hang
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : ahb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // m bit0 strobe A, bit1 strobe B, bit2 preset; low long enough to pass the filter
  task automatic pins(input logic [2:0] m);
    @(posedge clk_sys);
    loadAN <= ~m[0];
    loadBN <= ~m[1];
    async_preset_n <= ~m[2];
    repeat (6) @(posedge clk_sys);
    loadAN <= 1'b1;
    loadBN <= 1'b1;
    async_preset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask : pins

  task automatic send(input logic [11:0] w, input logic desel, input int slow);
    dds_host_model_i.send(w, desel, slow);
    repeat (4) @(posedge clk_sys);
  endtask : send

  // hang guard: counts as a mismatch and closes the run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk({20'h0, dacA_q}, 32'h0);
    rdchk(ADDR_CTRL, CTRL_RESET);
    rdchk(8'h40, 32'h0);
    ahb(1'b1, ADDR_CTRL, 32'h1);
    rdchk(ADDR_CTRL, 32'h1);
    ahb(1'b1, ADDR_CTRL, 32'h0);
    send(12'hA5C, 1'b0, 0);
    rdchk(ADDR_SHIFT, 32'hA5C);
    pins(3'b001);
    chk({20'h0, dacA_q}, 32'hA5C);
    chk({20'h0, dacB_q}, 32'h0);
    ahb(1'b1, ADDR_CTRL, 32'h1);
    pins(3'b010);
    chk({20'h0, dacB_q}, 32'h0);
    ahb(1'b1, ADDR_CTRL, 32'h0);
    send(12'h3B7, 1'b0, 20);
    send(12'hFFF, 1'b1, 0);
    rdchk(ADDR_SHIFT, 32'h3B7);
    pins(3'b010);
    chk({20'h0, dacB_q}, 32'h3B7);
    chk({20'h0, dacA_q}, 32'hA5C);
    rdchk(ADDR_DACB, 32'h3B7);
    presetHalf <= 1'b1;
    pins(3'b100);
    chk({20'h0, dacA_q}, {20'h0, CODE_HALF});
    chk({20'h0, dacB_q}, 32'h800);
    rdchk(ADDR_PINS, 32'h1 << PINS_MSBSEL_BIT);
    rdchk(ADDR_DACA, {20'h0, CODE_HALF});
    rdchk(ADDR_SHIFT, 32'h3B7);
    presetHalf <= 1'b0;
    pins(3'b100);
    chk({20'h0, dacA_q}, {20'h0, CODE_ZERO});
    chk({20'h0, dacB_q}, 32'h0);
    shutdownN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    send(12'h123, 1'b0, 0);
    pins(3'b011);
    chk({20'h0, dacA_q}, 32'h0);
    rdchk(ADDR_SHIFT, 32'h3B7);
    shutdownN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pins(3'b011);
    chk({20'h0, dacA_q}, 32'h3B7);
    chk({20'h0, dacB_q}, 32'h3B7);
    print_verdict();
  end
endmodule : tb_top
